// *** include/sah_pkg.sv ***
// Package of constants and types for the servo alarm and state error handler
package sah_pkg;
  // ==========================================================
  // APB register map (byte addresses)
  localparam logic [7:0] SAH_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SAH_ADDR_STAT = 8'h04;
  localparam logic [7:0] SAH_ADDR_IRQ = 8'h08;
  localparam logic [7:0] SAH_ADDR_MASK = 8'h0c;
  localparam logic [7:0] SAH_ADDR_HIST = 8'h10;
  localparam logic [7:0] SAH_ADDR_STATE = 8'h14;

  // ==========================================================
  // Control register fields
  localparam int SAH_CTRL_SEQ_LSB = 0;  // sequence_at_alarm_setting, 3 bits
  localparam int SAH_CTRL_RETRACT_LSB = 4;  // retract clear attributes
  localparam int SAH_CTRL_CLEAR_BIT = 8;  // write 1: alarm clear command
  localparam int SAH_CTRL_ABSCLR_BIT = 9;  // write 1: absolute clear
  localparam logic [2:0] SAH_SEQ_ESTOP_MIN = 3'h4;

  // ==========================================================
  // Status codes and request codes
  localparam logic [15:0] SAH_CODE_NONE = 16'h0000;
  localparam logic [15:0] SAH_CODE_ILLEGAL = 16'h0011;
  localparam logic [15:0] SAH_CODE_UNDEF = 16'h0012;
  localparam logic [3:0] SAH_REQ_INIT = 4'h1;
  localparam logic [3:0] SAH_REQ_PREOP = 4'h2;
  localparam logic [3:0] SAH_REQ_BOOT = 4'h3;
  localparam logic [3:0] SAH_REQ_SAFEOP = 4'h4;
  localparam logic [3:0] SAH_REQ_OP = 4'h8;

  // ==========================================================
  // Alarm identifiers (main number, sub number)
  localparam logic [7:0] SAH_ALM_ILLEGAL = 8'h80;  // 80.0
  localparam logic [7:0] SAH_ALM_UNDEF = 8'h81;  // 80.1
  localparam int SAH_HIST_DEPTH = 14;

  // ==========================================================
  // Timing
  localparam int SAH_CLK_MHZ = 125;
  localparam int SAH_OVL_WAIT_MS = 10000;
  localparam longint SAH_OVL_WAIT_CYC =
    longint'(SAH_OVL_WAIT_MS) * 1000 * SAH_CLK_MHZ;
  localparam int SAH_BLINK_MS = 200;
  localparam int SAH_BLINK_CYC = SAH_BLINK_MS * 1000 * SAH_CLK_MHZ;

  // Drive alarm sources presented on the alarm input vector
  typedef enum logic [3:0] {
    SAH_SRC_OVERLOAD,
    SAH_SRC_ABS_CNT_OVER,
    SAH_SRC_ABS_OVERSPEED,
    SAH_SRC_RET_IO,
    SAH_SRC_RET_COMM,
    SAH_SRC_RET_ERR,
    SAH_SRC_FORCED,
    SAH_SRC_CMD_ERR,
    SAH_SRC_HOME_ERR2,
    SAH_SRC_FATAL
  } sah_src_e;
  localparam int SAH_NSRC = 10;

  typedef enum logic [1:0] {
    SAH_ST_INIT,
    SAH_ST_PREOP,
    SAH_ST_SAFEOP,
    SAH_ST_OP
  } sah_state_e;
endpackage : sah_pkg

// *** src/sah_handler.sv ***
// Alarm attribute handling and state-change error detection block
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module sah_handler
  import sah_pkg::*;
#(
  parameter longint OVL_WAIT_CYC = SAH_OVL_WAIT_CYC,
  parameter int BLINK_CYC = SAH_BLINK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire logic [3:0] req_code,
  input wire logic [1:0] sync_mode,
  input wire logic [SAH_NSRC-1:0] alarm_in,
  input wire logic retract_active,
  input wire logic retract_done,
  output logic [1:0] esm_state,
  output logic [15:0] status_code,
  output logic err_led,
  output logic emergency_stop,
  output logic [7:0] display_alarm,
  output logic irq
);

  // ==========================================================
  // State
  // Packed struct cannot hold an unpacked array; history kept flat
  typedef struct packed {
    logic [2:0] seq;
    logic [2:0] ret_attr;
    logic [SAH_NSRC-1:0] active;
    logic [SAH_NSRC-1:0] seen;
    logic fb_alarm;
    logic [7:0] fb_num;
    logic abs_cleared;
    logic [39:0] ovl_cnt;
    logic ovl_ok;
    logic clr_pend;
    sah_state_e state;
    logic [15:0] code;
    logic [7:0] first;
    logic first_valid;
    logic estop;
    logic [31:0] blink_cnt;
    logic blink;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [3:0] hist_cnt;
    logic [SAH_HIST_DEPTH*8-1:0] hist;
    logic [31:0] rdata;
  } sah_state_s;

  sah_state_s st_r;
  sah_state_s st_nxt;

  // ==========================================================
  // Helper functions
  // Number shown for a drive alarm source
  function automatic logic [7:0] src_num(input int i);
    case (i)
      SAH_SRC_OVERLOAD: src_num = 8'h16;
      SAH_SRC_ABS_CNT_OVER: src_num = 8'h40;
      SAH_SRC_ABS_OVERSPEED: src_num = 8'h42;
      SAH_SRC_RET_IO, SAH_SRC_RET_COMM, SAH_SRC_RET_ERR: src_num = 8'h87;
      SAH_SRC_FORCED: src_num = 8'h87;
      SAH_SRC_CMD_ERR: src_num = 8'h91;
      SAH_SRC_HOME_ERR2: src_num = 8'h94;
      default: src_num = 8'h96;
    endcase
  endfunction : src_num

  // History attribute per source
  function automatic logic src_hist(input int i);
    src_hist = (i != SAH_SRC_FORCED);
  endfunction : src_hist

  // Emergency-stop attribute per source
  function automatic logic src_estop(input int i);
    case (i)
      SAH_SRC_FORCED, SAH_SRC_RET_IO, SAH_SRC_RET_COMM, SAH_SRC_RET_ERR:
        src_estop = 1'b1;
      default: src_estop = 1'b0;
    endcase
  endfunction : src_estop

  // Decide whether a request is illegal from the present state
  function automatic logic is_illegal(input sah_state_e s,
                                      input logic [3:0] r);
    is_illegal = 1'b0;
    if (r == SAH_REQ_BOOT && s != SAH_ST_INIT) is_illegal = 1'b1;
    if (s == SAH_ST_INIT && (r == SAH_REQ_SAFEOP || r == SAH_REQ_OP))
      is_illegal = 1'b1;
    if (s == SAH_ST_PREOP && r == SAH_REQ_OP) is_illegal = 1'b1;
  endfunction : is_illegal

  logic apb_wr;
  logic apb_rd;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [SAH_NSRC-1:0] clearable;
    logic [SAH_NSRC-1:0] rise;
    logic do_clear;
    logic undef;
    logic illegal;
    clearable = '0;
    rise = '0;
    do_clear = 1'b0;
    undef = 1'b0;
    illegal = 1'b0;
    st_nxt = st_r;
    st_nxt.rdata = '0;

    // Register writes
    if (apb_wr) begin
      case (paddr)
        SAH_ADDR_CTRL: begin
          st_nxt.seq = pwdata[SAH_CTRL_SEQ_LSB +: 3];
          st_nxt.ret_attr = pwdata[SAH_CTRL_RETRACT_LSB +: 3];
          if (pwdata[SAH_CTRL_CLEAR_BIT]) st_nxt.clr_pend = 1'b1;
          if (pwdata[SAH_CTRL_ABSCLR_BIT]) st_nxt.abs_cleared = 1'b1;
        end
        SAH_ADDR_MASK: st_nxt.irq_mask = pwdata[3:0];
        default: ;
      endcase
    end

    // Clearable attribute per source
    clearable[SAH_SRC_OVERLOAD] = st_r.ovl_ok;
    clearable[SAH_SRC_ABS_CNT_OVER] = st_r.abs_cleared;
    clearable[SAH_SRC_ABS_OVERSPEED] = st_r.abs_cleared;
    clearable[SAH_SRC_RET_IO] = st_r.ret_attr[0];
    clearable[SAH_SRC_RET_COMM] = st_r.ret_attr[1];
    clearable[SAH_SRC_RET_ERR] = st_r.ret_attr[2];
    clearable[SAH_SRC_FORCED] = 1'b1;
    clearable[SAH_SRC_CMD_ERR] = 1'b1;
    clearable[SAH_SRC_HOME_ERR2] = 1'b1;

    // Detect new drive alarms; retract alarms wait for completion
    for (int i = 0; i < SAH_NSRC; i++) begin
      if (alarm_in[i] && !st_r.seen[i]) begin
        if (i >= SAH_SRC_RET_IO && i <= SAH_SRC_RET_ERR &&
            retract_active && !retract_done) begin
          rise[i] = 1'b0;
        end else begin
          rise[i] = 1'b1;
        end
      end
      if (!alarm_in[i]) st_nxt.seen[i] = 1'b0;
    end

    // Raise drive alarms, log history and latch the first number
    for (int i = 0; i < SAH_NSRC; i++) begin
      if (rise[i]) begin
        st_nxt.seen[i] = 1'b1;
        st_nxt.active[i] = 1'b1;
        if (src_hist(i)) begin
          st_nxt.hist = {st_nxt.hist[SAH_HIST_DEPTH*8-9:0], src_num(i)};
          if (st_nxt.hist_cnt != 4'(SAH_HIST_DEPTH))
            st_nxt.hist_cnt = st_nxt.hist_cnt + 4'h1;
        end
        if (!st_nxt.first_valid) begin
          st_nxt.first = src_num(i);
          st_nxt.first_valid = 1'b1;
        end
        if (i == SAH_SRC_OVERLOAD) begin
          st_nxt.ovl_cnt = '0;
          st_nxt.ovl_ok = 1'b0;
        end
        if (i == SAH_SRC_ABS_CNT_OVER || i == SAH_SRC_ABS_OVERSPEED)
          st_nxt.abs_cleared = 1'b0;
        st_nxt.irq_stat[0] = 1'b1;
      end
    end

    // Overload clear wait
    if (st_r.active[SAH_SRC_OVERLOAD] && !st_r.ovl_ok) begin
      if (st_r.ovl_cnt >= 40'(OVL_WAIT_CYC - 1)) st_nxt.ovl_ok = 1'b1;
      else st_nxt.ovl_cnt = st_r.ovl_cnt + 40'h1;
    end

    // State-change requests, checked in every state and sync mode
    if (req_valid) begin
      undef = !(req_code == SAH_REQ_INIT || req_code == SAH_REQ_PREOP ||
                req_code == SAH_REQ_BOOT || req_code == SAH_REQ_SAFEOP ||
                req_code == SAH_REQ_OP);
      illegal = !undef && is_illegal(st_r.state, req_code);
      if (illegal || undef) begin
        st_nxt.fb_alarm = 1'b1;
        st_nxt.fb_num = illegal ? SAH_ALM_ILLEGAL : SAH_ALM_UNDEF;
        st_nxt.code = illegal ? SAH_CODE_ILLEGAL : SAH_CODE_UNDEF;
        if (st_r.state == SAH_ST_OP)
          st_nxt.state = SAH_ST_SAFEOP;
        st_nxt.hist = {st_nxt.hist[SAH_HIST_DEPTH*8-9:0], st_nxt.fb_num};
        if (st_nxt.hist_cnt != 4'(SAH_HIST_DEPTH))
          st_nxt.hist_cnt = st_nxt.hist_cnt + 4'h1;
        if (!st_nxt.first_valid) begin
          st_nxt.first = st_nxt.fb_num;
          st_nxt.first_valid = 1'b1;
        end
        st_nxt.irq_stat[1] = 1'b1;
      end else if (req_code != SAH_REQ_BOOT) begin
        case (req_code)
          SAH_REQ_INIT: st_nxt.state = SAH_ST_INIT;
          SAH_REQ_PREOP: st_nxt.state = SAH_ST_PREOP;
          SAH_REQ_SAFEOP: st_nxt.state = SAH_ST_SAFEOP;
          SAH_REQ_OP: st_nxt.state = SAH_ST_OP;
          default: ;
        endcase
        st_nxt.irq_stat[3] = 1'b1;
      end
    end

    // Clear processing once every active alarm is clearable
    if (st_r.clr_pend) begin
      if ((st_r.active & ~clearable) == '0) begin
        do_clear = 1'b1;
        st_nxt.clr_pend = 1'b0;
      end
    end
    if (do_clear) begin
      st_nxt.active = st_nxt.active & ~rise;
      st_nxt.active = '0;
      st_nxt.fb_alarm = 1'b0;
      st_nxt.code = SAH_CODE_NONE;
      st_nxt.first_valid = 1'b0;
      st_nxt.first = '0;
      st_nxt.ovl_ok = 1'b0;
      st_nxt.irq_stat[2] = 1'b1;
    end

    // Emergency stop for sequence settings 4 to 7; an active retract alarm stops at any setting
    st_nxt.estop = 1'b0;
    for (int i = 0; i < SAH_NSRC; i++) begin
      if (st_nxt.active[i] && src_estop(i) &&
          st_r.seq >= SAH_SEQ_ESTOP_MIN)
        st_nxt.estop = 1'b1;
      if (st_nxt.active[i] && i >= SAH_SRC_RET_IO && i <= SAH_SRC_RET_ERR)
        st_nxt.estop = 1'b1;
    end

    // Blink timer for the error indicator
    if (st_r.blink_cnt >= 32'(BLINK_CYC - 1)) begin
      st_nxt.blink_cnt = '0;
      st_nxt.blink = !st_r.blink;
    end else begin
      st_nxt.blink_cnt = st_r.blink_cnt + 32'h1;
    end

    // Register reads; reading the interrupt status clears it
    if (apb_rd) begin
      case (paddr)
        SAH_ADDR_CTRL: st_nxt.rdata = 32'({st_r.ret_attr, 1'b0, st_r.seq});
        SAH_ADDR_STAT: st_nxt.rdata = {st_r.code, st_r.first,
                                       st_r.fb_num[3:0], 2'h0, st_r.state};
        SAH_ADDR_IRQ: begin
          st_nxt.rdata = 32'(st_r.irq_stat);
          st_nxt.irq_stat = st_nxt.irq_stat & ~st_r.irq_stat;
        end
        SAH_ADDR_MASK: st_nxt.rdata = 32'(st_r.irq_mask);
        SAH_ADDR_HIST: st_nxt.rdata = {st_r.hist[15:0], 12'h000,
                                       st_r.hist_cnt};
        SAH_ADDR_STATE: st_nxt.rdata = 32'(st_r.active);
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs; one wait state lets read data come from a flip-flop
  logic wait_r;
  always_ff @(posedge ref_clk) begin
    if (rst) wait_r <= 1'b0;
    else wait_r <= psel && penable && !wait_r;
  end
  assign pready = wait_r;
  assign pslverr = 1'b0;
  assign prdata = st_r.rdata;
  assign esm_state = st_r.state;
  assign status_code = st_r.code;
  assign err_led = st_r.fb_alarm && st_r.blink;
  assign emergency_stop = st_r.estop;
  assign display_alarm = st_r.first;
  assign irq = |(st_r.irq_stat & st_r.irq_mask);
endmodule : sah_handler

// *** verification/sah_handler_asserts.sv ***
// Checker of request handling, display latch and indicator rules
`timescale 1ns/1ps
module sah_handler_asserts
  import sah_pkg::*;
#(
  parameter longint OVL_WAIT_CYC = 20,
  parameter int BLINK_CYC = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic req_valid,
  input wire logic [3:0] req_code,
  input wire logic [1:0] esm_state,
  input wire logic [15:0] status_code,
  input wire logic err_led,
  input wire logic [7:0] display_alarm
);
  // ==========================================================
  // Request classes
  logic bad;
  logic undef;
  logic legal;
  logic [1:0] tgt;
  logic [7:0] still_cnt;
  assign undef = !(req_code inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8});
  assign bad = (esm_state == 2'h0 && req_code inside {4'h4, 4'h8})
    || (esm_state == 2'h1 && req_code == 4'h8)
    || (esm_state != 2'h0 && req_code == 4'h3);
  assign legal = !bad && !undef && req_code != 4'h3;
  assign tgt = req_code == 4'h1 ? 2'h0 : req_code == 4'h2 ? 2'h1 :
    req_code == 4'h4 ? 2'h2 : 2'h3;
  // Idle indicator count; a stuck led while alarmed grows it
  always_ff @(posedge ref_clk) begin
    if (rst || status_code == 16'h0 || err_led != $past(err_led))
      still_cnt <= 8'h0;
    else if (still_cnt != 8'hff)
      still_cnt <= still_cnt + 8'h1;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_access;
    psel && penable && !$past(penable);
  endsequence
  a_apb_wait: assert property (s_access |-> !pready ##1 pready)
    else $error("apb wait state wrong");
  a_no_slverr: assert property (!pslverr)
    else $error("slave error raised");
  a_illegal_code: assert property (
    req_valid && bad |=> status_code == SAH_CODE_ILLEGAL)
    else $error("illegal request code wrong");
  a_op_fallback: assert property (
    req_valid && (bad || undef) && esm_state == 2'h3 |=> esm_state == 2'h2)
    else $error("op did not fall to safeop");
  a_illegal_stay: assert property (
    req_valid && bad && esm_state != 2'h3 |=> $stable(esm_state))
    else $error("state moved on illegal request");
  a_undef_code: assert property (
    req_valid && undef |=> status_code == SAH_CODE_UNDEF)
    else $error("undefined request code wrong");
  a_legal_move: assert property (
    req_valid && legal |=> esm_state == $past(tgt)
    && $stable(status_code) && $stable(display_alarm))
    else $error("legal request mishandled");
  a_first_latch: assert property (
    req_valid && bad && display_alarm == 8'h0
    |=> display_alarm == SAH_ALM_ILLEGAL)
    else $error("first alarm not latched");
  a_first_held: assert property (
    req_valid && display_alarm != 8'h0 |=> $stable(display_alarm))
    else $error("first alarm overwritten");
  a_blink_runs: assert property (
    still_cnt < 8'(3 * BLINK_CYC))
    else $error("indicator not blinking");
  a_led_off_idle: assert property (
    status_code == SAH_CODE_NONE [*2] |-> !err_led)
    else $error("indicator lit without alarm");
endmodule : sah_handler_asserts

bind sah_handler sah_handler_asserts #(.OVL_WAIT_CYC(OVL_WAIT_CYC),
  .BLINK_CYC(BLINK_CYC)) u_chk (.ref_clk, .rst, .psel, .penable, .pready,
  .pslverr, .req_valid, .req_code, .esm_state, .status_code, .err_led,
  .display_alarm);

// *** verification/sah_host_model.sv ***
// Host controller model issuing fieldbus state-change requests
`timescale 1ns/1ps
module sah_host_model
  import sah_pkg::*;
(
  input wire logic ref_clk,
  output logic req_valid,
  output logic [3:0] req_code
);
  // ==========================================================
  // Idle code is inverted so the value left by a defined request never looks like a request
  initial begin
    req_valid = 1'b0;
    req_code = 4'h5;
  end
  // Request code for a target state
  function automatic logic [3:0] code_of(input sah_state_e s);
    case (s)
      SAH_ST_INIT: code_of = SAH_REQ_INIT;
      SAH_ST_PREOP: code_of = SAH_REQ_PREOP;
      SAH_ST_SAFEOP: code_of = SAH_REQ_SAFEOP;
      default: code_of = SAH_REQ_OP;
    endcase
  endfunction : code_of
  // One-cycle request pulse
  task automatic send(input logic [3:0] c);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_code <= c;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    req_code <= ~c;
  endtask : send
endmodule : sah_host_model

// *** verification/sah_handler_tb.sv ***
// Self-checking bench for the alarm and state error handler
`timescale 1ns/1ps
module sah_handler_tb
  import sah_pkg::*;
  ;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, ctrl = 32'h0, seed = 32'h0749;
  logic pready, pslverr, req_valid, err_led, emergency_stop, irq;
  logic [3:0] req_code;
  logic [1:0] sync_mode = 2'h0, esm_state;
  logic [SAH_NSRC-1:0] alarm_in = '0;
  logic [15:0] status_code;
  logic [7:0] display_alarm;
  logic [3:0] dir [11] = '{4'h4, 4'h8, 4'h2, 4'h8, 4'h3, 4'h4, 4'h3,
    4'h8, 4'h3, 4'h8, 4'h5};
  int fails = 0, n_checks = 0, cyc = 0, m_state = 0, m_code = 0, m_disp = 0;
  // ==========================================================
  // Clock, partner and design
  initial forever #4 ref_clk = ~ref_clk;
  sah_host_model host (.ref_clk, .req_valid, .req_code);
  sah_handler #(.OVL_WAIT_CYC(20), .BLINK_CYC(4)) uut (.ref_clk, .rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .req_valid, .req_code, .sync_mode, .alarm_in, .retract_active(1'b0),
    .retract_done(1'b0), .esm_state, .status_code, .err_led,
    .emergency_stop, .display_alarm, .irq);
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_esm();
    cmp(32'(esm_state), 32'(m_state));
    cmp(32'(status_code), 32'(m_code));
    cmp(32'(display_alarm), 32'(m_disp));
  endtask : cmp_esm
  // Holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic req(input logic [3:0] c);
    bit bad, und;
    bad = (m_state == 0 && c inside {4'h4, 4'h8}) ||
      (m_state == 1 && c == 4'h8) || (m_state != 0 && c == 4'h3);
    und = !(c inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8});
    seed = xs(seed);
    sync_mode <= seed[1:0];
    host.send(c);
    if (bad || und) begin
      m_code = bad ? 'h11 : 'h12;
      if (m_disp == 0) m_disp = bad ? 'h80 : 'h81;
      if (m_state == 3) m_state = 2;
    end else if (c != 4'h3)
      m_state = c == 1 ? 0 : c == 2 ? 1 : c == 4 ? 2 : 3;
    @(posedge ref_clk);
    #1 cmp_esm();
  endtask : req
  // Wait covers the overload hold-off; a refused clear leaves all as is
  task automatic clr(input bit ok);
    apb(1'b1, SAH_ADDR_CTRL, ctrl | 32'h100);
    repeat (30) @(posedge ref_clk);
    if (ok) begin
      m_code = 0;
      m_disp = 0;
    end
    #1 cmp_esm();
  endtask : clr
  task automatic pulse(input int i);
    @(posedge ref_clk);
    alarm_in[i] <= 1'b1;
    @(posedge ref_clk);
    alarm_in <= '0;
  endtask : pulse
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1 cmp_esm();
    foreach (dir[i]) req(dir[i]);
    clr(1'b1);
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      req(m_state == 0 && seed[7:4] == 4'h3 ? 4'h2 : seed[7:4]);
    end
    $display("test requests done");
    clr(1'b1);
    apb(1'b1, SAH_ADDR_MASK, 32'h2);
    req(4'h9);
    cmp(32'(irq), 32'h1);
    apb(1'b0, SAH_ADDR_IRQ, 32'h0);
    cmp(rd & 32'h2, 32'h2);
    @(posedge ref_clk);
    #1 cmp(32'(irq), 32'h0);
    apb(1'b1, SAH_ADDR_MASK, 32'h0);
    req(4'h9);
    cmp(32'(irq), 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    cmp(rd, 32'h0);
    $display("test interrupts done");
    clr(1'b1);
    req(4'h9);
    pulse(0);
    apb(1'b1, SAH_ADDR_CTRL, 32'h100);
    repeat (4) @(posedge ref_clk);
    #1 cmp(32'(status_code), 32'h12);
    clr(1'b1);
    for (int i = 1; i < 6; i++) begin
      req(4'h9);
      pulse(i);
      clr(1'b0);
      if (i < 3) apb(1'b1, SAH_ADDR_CTRL, 32'h200);
      else ctrl = 32'h1 << (i + 1);
      clr(1'b1);
      ctrl = 32'h0;
    end
    $display("test clear attributes done");
    for (int s = 3; s < 5; s++) begin
      ctrl = 32'(s);
      apb(1'b1, SAH_ADDR_CTRL, ctrl);
      pulse(6);
      m_disp = 'h87;
      repeat (4) @(posedge ref_clk);
      #1 cmp(32'(emergency_stop), 32'(s == 4));
      pulse(7);
      pulse(8);
      req(4'h9);
      clr(1'b1);
    end
    pulse(9);
    repeat (10) @(posedge ref_clk);
    #1 cmp(32'({err_led, status_code}), 32'h0);
    rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    {m_state, m_code, m_disp} = '0;
    @(posedge ref_clk);
    #1 cmp_esm();
    $display("test drive alarms done");
    conclude();
  end
endmodule : sah_handler_tb
